// file: pkg/cpm_defines.svh
// constants for the charge port mode and load detection controller
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH

// timebase: one tick per millisecond
`define CPM_CLK_MHZ 100
`define CPM_TICK_US 1000
`define CPM_TICK_W 17
`define CPM_CNT_W 16

// qualification times in milliseconds
`define CPM_ASSERT_MS 200
`define CPM_RELEASE_MS 3000
`define CPM_SLEEP_MS 15000
`define CPM_WAKE_DISCH_MS 2000
`define CPM_SWITCH_DISCH_MS 500

// register map, byte addresses
`define CPM_ADDR_W 12
`define CPM_ADDR_CTRL 12'h000
`define CPM_ADDR_STATUS 12'h004

// control register layout and reset value
`define CPM_CTRL_AUTOSW 0
`define CPM_CTRL_RESET 32'h0000_0001
`define CPM_STATUS_PAD_W 18

`endif

// file: pkg/cpm_pkg.sv
// types for the charge port mode and load detection controller
package cpm_pkg;
`include "cpm_defines.svh"

    typedef enum logic [2:0] {
        MODE_DISCHARGE, MODE_AUTO, MODE_PLAIN, MODE_SHORTED,
        MODE_DIVIDER, MODE_PAIRED, MODE_CDP
    } mode_e;

    typedef enum logic [1:0] {DET_NONE, DET_LOW_DRAIN, DET_BUDGET} det_e;

    typedef enum logic [1:0] {LD_CHARGE, LD_SLEEP, LD_WAKE} ld_e;

    typedef enum logic [1:0] {AS_IDLE, AS_DISCH, AS_SDP} as_e;

    // pin and comparator inputs, in synchroniser order
    typedef struct packed {
        logic mode_select_a;
        logic mode_select_b;
        logic mode_select_c;
        logic limit_choice;
        logic above_lo_plus;
        logic below_lo_minus;
        logic below_wake;
        logic at_wake_limit;
        logic bc12_primary;
        logic hid_detected;
        logic phone_dcp_no_data;
        logic phone_sdp_connected;
    } pins_s;

    typedef struct packed {
        pins_s s1;
        pins_s s2;
        logic [`CPM_TICK_W-1:0] tick_cnt;
        logic tick;
        mode_e mode;
        det_e det;
        ld_e ld;
        as_e as_st;
        logic pb_on;
        logic [`CPM_CNT_W-1:0] ld_cnt;
        logic [`CPM_CNT_W-1:0] pb_cnt;
        logic [`CPM_CNT_W-1:0] as_cnt;
        logic lp_n;
        logic disch;
        logic upper;
        logic lim55;
        logic data_on;
        logic [31:0] ctrl;
        logic [31:0] prdata;
        logic pslverr;
    } st_s;

endpackage : cpm_pkg

// file: hw/charge_port_mode_load_detect.sv
// charge port mode decode, load detection and cdp/sdp auto switch
`timescale 1ns/1ps

module charge_port_mode_load_detect #(
    parameter int TICK_CYCLES = `CPM_CLK_MHZ * `CPM_TICK_US
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [`CPM_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mode pins
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic mode_select_c,
    input wire logic limit_choice,
    // current comparators and port sensing
    input wire logic above_lo_plus,
    input wire logic below_lo_minus,
    input wire logic below_wake,
    input wire logic at_wake_limit,
    input wire logic bc12_primary,
    input wire logic hid_detected,
    input wire logic phone_dcp_no_data,
    input wire logic phone_sdp_connected,
    // port control
    output logic load_present_n,
    output logic port_discharge,
    output logic port_power_on,
    output logic upper_limit_sel,
    output logic wake_limit_sel,
    output logic data_lines_on
);

    localparam logic [`CPM_TICK_W-1:0] TICK_LAST =
        `CPM_TICK_W'(TICK_CYCLES - 1);
    localparam logic [`CPM_CNT_W-1:0] CNT_ONE = `CPM_CNT_W'(1);

    cpm_pkg::st_s q;
    cpm_pkg::st_s n;
    cpm_pkg::pins_s raw;
    cpm_pkg::pins_s p;

    assign raw = '{mode_select_a, mode_select_b, mode_select_c, limit_choice,
        above_lo_plus, below_lo_minus, below_wake, at_wake_limit,
        bc12_primary, hid_detected, phone_dcp_no_data, phone_sdp_connected};

    always_comb begin
        logic [2:0] sel;
        cpm_pkg::mode_e cmd_mode;
        cpm_pkg::det_e cmd_det;
        logic data_mode;
        sel = 3'h0;
        cmd_mode = cpm_pkg::MODE_DISCHARGE;
        cmd_det = cpm_pkg::DET_NONE;
        data_mode = 1'b0;
        n = q;
        n.s1 = raw;
        n.s2 = q.s1;
        p = q.s2;

        n.tick = 1'b0;
        n.tick_cnt = q.tick_cnt + `CPM_TICK_W'(1);
        if (q.tick_cnt == TICK_LAST) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end

        // pin decode
        sel = {p.mode_select_a, p.mode_select_b, p.mode_select_c};
        unique case (sel)
            3'h0: cmd_mode = cpm_pkg::MODE_DISCHARGE;
            3'h1: begin
                cmd_mode = cpm_pkg::MODE_AUTO;
                cmd_det = p.limit_choice ? cpm_pkg::DET_LOW_DRAIN
                                         : cpm_pkg::DET_NONE;
            end
            3'h2: cmd_mode = cpm_pkg::MODE_PLAIN;
            3'h3: begin
                cmd_mode = cpm_pkg::MODE_AUTO;
                cmd_det = p.limit_choice ? cpm_pkg::DET_BUDGET
                                         : cpm_pkg::DET_NONE;
            end
            3'h4: cmd_mode = cpm_pkg::MODE_SHORTED;
            3'h5: cmd_mode = cpm_pkg::MODE_DIVIDER;
            3'h6: cmd_mode = cpm_pkg::MODE_PLAIN;
            3'h7: begin
                cmd_mode = p.limit_choice ? cpm_pkg::MODE_CDP
                                          : cpm_pkg::MODE_PAIRED;
                cmd_det = p.limit_choice ? cpm_pkg::DET_BUDGET
                                         : cpm_pkg::DET_NONE;
            end
        endcase

        // follow pins, hid holds a data mode against auto
        data_mode = (q.mode == cpm_pkg::MODE_PLAIN) ||
                    (q.mode == cpm_pkg::MODE_PAIRED) ||
                    (q.mode == cpm_pkg::MODE_CDP);
        if (!(p.hid_detected && data_mode &&
              cmd_mode == cpm_pkg::MODE_AUTO)) begin
            n.mode = cmd_mode;
            n.det = cmd_det;
        end

        // new detection scheme starts from a clean slate
        if (n.det != q.det) begin
            n.ld = cpm_pkg::LD_CHARGE;
            n.pb_on = 1'b0;
            n.ld_cnt = '0;
            n.pb_cnt = '0;
        end else if (n.det == cpm_pkg::DET_LOW_DRAIN) begin
            unique case (q.ld)
                cpm_pkg::LD_CHARGE: begin
                    if (!p.below_wake) begin
                        n.ld_cnt = '0;
                    end else if (q.tick) begin
                        n.ld_cnt = q.ld_cnt + CNT_ONE;
                        if (q.ld_cnt == `CPM_CNT_W'(`CPM_SLEEP_MS)) begin
                            n.ld = cpm_pkg::LD_SLEEP;
                            n.ld_cnt = '0;
                        end
                    end
                end
                cpm_pkg::LD_SLEEP: begin
                    if (p.at_wake_limit) begin
                        n.ld = cpm_pkg::LD_WAKE;
                        n.ld_cnt = '0;
                    end
                end
                cpm_pkg::LD_WAKE: begin
                    if (q.tick) begin
                        n.ld_cnt = q.ld_cnt + CNT_ONE;
                        if (q.ld_cnt ==
                            `CPM_CNT_W'(`CPM_WAKE_DISCH_MS)) begin
                            n.ld = cpm_pkg::LD_CHARGE;
                            n.ld_cnt = '0;
                        end
                    end
                end
                default: n.ld = cpm_pkg::LD_CHARGE;
            endcase
        end else if (n.det == cpm_pkg::DET_BUDGET) begin
            if (!q.pb_on) begin
                // primary detection asserts at once in cdp
                if (n.mode == cpm_pkg::MODE_CDP && p.bc12_primary) begin
                    n.pb_on = 1'b1;
                    n.pb_cnt = '0;
                end else if (!p.above_lo_plus) begin
                    n.pb_cnt = '0;
                end else if (q.tick) begin
                    n.pb_cnt = q.pb_cnt + CNT_ONE;
                    if (q.pb_cnt == `CPM_CNT_W'(`CPM_ASSERT_MS - 1)) begin
                        n.pb_on = 1'b1;
                        n.pb_cnt = '0;
                    end
                end
            end else begin
                if (!p.below_lo_minus) begin
                    n.pb_cnt = '0;
                end else if (q.tick) begin
                    n.pb_cnt = q.pb_cnt + CNT_ONE;
                    if (q.pb_cnt == `CPM_CNT_W'(`CPM_RELEASE_MS - 1)) begin
                        n.pb_on = 1'b0;
                        n.pb_cnt = '0;
                    end
                end
            end
        end

        // cdp/sdp auto switch, enabled from the control register
        if (n.mode != cpm_pkg::MODE_CDP || !q.ctrl[`CPM_CTRL_AUTOSW]) begin
            n.as_st = cpm_pkg::AS_IDLE;
            n.as_cnt = '0;
        end else begin
            unique case (q.as_st)
                cpm_pkg::AS_IDLE: begin
                    if (p.phone_dcp_no_data) begin
                        n.as_st = cpm_pkg::AS_DISCH;
                        n.as_cnt = '0;
                    end
                end
                cpm_pkg::AS_DISCH: begin
                    if (q.tick) begin
                        n.as_cnt = q.as_cnt + CNT_ONE;
                        if (q.as_cnt ==
                            `CPM_CNT_W'(`CPM_SWITCH_DISCH_MS)) begin
                            n.as_st = cpm_pkg::AS_SDP;
                        end
                    end
                end
                cpm_pkg::AS_SDP: begin
                    // back to cdp, port stays powered
                    if (p.phone_sdp_connected) begin
                        n.as_st = cpm_pkg::AS_IDLE;
                    end
                end
                default: n.as_st = cpm_pkg::AS_IDLE;
            endcase
        end

        // port outputs; pin swaps between data modes never discharge, the auto switch to sdp does
        n.disch = (n.mode == cpm_pkg::MODE_DISCHARGE) ||
                  (n.det == cpm_pkg::DET_LOW_DRAIN &&
                   n.ld == cpm_pkg::LD_WAKE) ||
                  (n.as_st == cpm_pkg::AS_DISCH);
        unique case (n.mode)
            cpm_pkg::MODE_DISCHARGE: n.upper = 1'b0;
            cpm_pkg::MODE_AUTO: n.upper = 1'b1;
            cpm_pkg::MODE_PAIRED: n.upper = 1'b0;
            cpm_pkg::MODE_CDP: n.upper = (n.as_st == cpm_pkg::AS_IDLE);
            default: n.upper = p.limit_choice;
        endcase
        n.lim55 = (n.det == cpm_pkg::DET_LOW_DRAIN &&
                   n.ld == cpm_pkg::LD_SLEEP);
        // low drain flag low except while asleep
        unique case (n.det)
            cpm_pkg::DET_LOW_DRAIN: n.lp_n = (n.ld == cpm_pkg::LD_SLEEP);
            cpm_pkg::DET_BUDGET: n.lp_n = !n.pb_on;
            default: n.lp_n = 1'b1;
        endcase
        n.data_on = (n.mode == cpm_pkg::MODE_PLAIN ||
                     n.mode == cpm_pkg::MODE_PAIRED ||
                     n.mode == cpm_pkg::MODE_CDP) &&
                    (n.as_st != cpm_pkg::AS_DISCH);

        // apb: answer prepared in setup, zero wait states
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            unique case (paddr)
                `CPM_ADDR_CTRL: n.prdata = q.ctrl;
                `CPM_ADDR_STATUS: n.prdata = {
                    `CPM_STATUS_PAD_W'(0), q.as_st, q.ld, q.det, q.mode,
                    q.data_on, q.lim55, q.upper, q.disch, q.lp_n};
                default: begin
                    n.prdata = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite && paddr == `CPM_ADDR_CTRL &&
            pstrb[0]) begin
            n.ctrl[7:0] = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.lp_n <= 1'b1;
            q.ctrl <= `CPM_CTRL_RESET;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = q.pslverr && psel && penable;
    assign load_present_n = q.lp_n;
    assign port_discharge = q.disch;
    assign port_power_on = !q.disch;
    assign upper_limit_sel = q.upper;
    assign wake_limit_sel = q.lim55;
    assign data_lines_on = q.data_on;

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence paired_then_cdp;
        q.mode == cpm_pkg::MODE_PAIRED ##1 q.mode == cpm_pkg::MODE_CDP;
    endsequence
    sequence sleep_then_wake;
        q.ld == cpm_pkg::LD_SLEEP ##1 q.ld == cpm_pkg::LD_WAKE;
    endsequence
    sequence sdp_then_cdp;
        q.as_st == cpm_pkg::AS_SDP ##1 q.as_st == cpm_pkg::AS_IDLE;
    endsequence

    a_paired_mode: assert property (
        (q.s2.mode_select_a && q.s2.mode_select_b && q.s2.mode_select_c &&
         !q.s2.limit_choice) |=> (q.mode == cpm_pkg::MODE_PAIRED && !q.upper))
        else $error("paired pins did not give paired mode, lower limit");
    a_cdp_upper: assert property (
        (q.mode == cpm_pkg::MODE_CDP && q.as_st == cpm_pkg::AS_IDLE)
        |-> (q.upper && q.det == cpm_pkg::DET_BUDGET))
        else $error("cdp without upper limit or budget detection");
    a_auto_quiet: assert property (
        (q.mode == cpm_pkg::MODE_AUTO && q.det == cpm_pkg::DET_NONE)
        |-> (q.lp_n && q.upper))
        else $error("auto mode without detection drove load flag");
    a_plain_limit: assert property (
        (q.mode == cpm_pkg::MODE_PLAIN) |-> q.upper == $past(q.s2.limit_choice))
        else $error("plain data port limit not following choice");
    a_sleep_entry: assert property (
        $rose(q.ld == cpm_pkg::LD_SLEEP) && q.det == cpm_pkg::DET_LOW_DRAIN
        |-> (q.lp_n && q.lim55 && $past(q.s2.below_wake)))
        else $error("low drain sleep entered wrongly");
    a_wake_disch: assert property (
        sleep_then_wake |-> (!q.lp_n && q.disch && !q.lim55))
        else $error("wake did not assert flag and discharge");
    a_budget_on: assert property (
        $rose(q.pb_on) && $stable(q.det) |->
        $past(q.s2.above_lo_plus) || $past(q.s2.bc12_primary))
        else $error("budget flag asserted without high load");
    a_budget_off: assert property (
        $fell(q.pb_on) && $stable(q.det) |-> $past(q.s2.below_lo_minus))
        else $error("budget flag released without low load");
    a_swap_no_disch: assert property (
        paired_then_cdp |-> !q.disch)
        else $error("paired to cdp swap discharged the port");
    a_switch_disch: assert property (
        (q.as_st == cpm_pkg::AS_DISCH) |-> (q.disch && !q.data_on))
        else $error("auto switch discharge not driven");
    a_switch_back: assert property (
        sdp_then_cdp |-> (!q.disch && q.upper))
        else $error("return to cdp discharged the port");
    a_shorted_limit: assert property (
        (q.mode == cpm_pkg::MODE_SHORTED) |->
        (q.upper == $past(q.s2.limit_choice) && !q.data_on))
        else $error("shorted charger limit wrong");

endmodule : charge_port_mode_load_detect

// file: verification/sys_power_model.sv
// system power controller model that drives the mode pins of one port
`timescale 1ns/1ps

module sys_power_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requested setting and load flags
    input wire logic [3:0] req,
    input wire logic load_present_n,
    input wire logic other_load_n,
    // mode pins
    output logic mode_select_a,
    output logic mode_select_b,
    output logic mode_select_c,
    output logic limit_choice
);
    logic [3:0] pins_q;

    // budget reallocation
    // budget of one port: a loaded neighbour parks an idle cdp port as sdp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= 4'h0;
        end else if (req == 4'hf && !other_load_n && load_present_n) begin
            pins_q <= 4'he;
        end else begin
            pins_q <= req;
        end
    end

    assign {mode_select_a, mode_select_b, mode_select_c, limit_choice} = pins_q;
endmodule : sys_power_model

// file: verification/tb_top.sv
// self-checking bench for the charge port mode and load detection block
`timescale 1ns/1ps
`include "cpm_defines.svh"

module tb_top;
    localparam int TC = 2;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_s;
    logic pclk = 1'b0, presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, a, b, c, ch;
    logic above = 1'b0, below = 1'b0, bwake = 1'b0, atw = 1'b0;
    logic bc12 = 1'b0, hid = 1'b0, pdcp = 1'b0, psdp = 1'b0;
    logic lp_n, dis, pwr, up, wk, dat, other_n = 1'b1, seen = 1'b0;
    logic [3:0] req = 4'h0;
    note_s notes[$];
    note_s nt;
    int fail_count = 0, cmp_count = 0, i, g;
    logic [31:0] tab [16] = '{32'h003, 32'h003, 32'h025, 32'h124, 32'h051,
        32'h055, 32'h025, 32'h225, 32'h061, 32'h065, 32'h081, 32'h085,
        32'h051, 32'h055, 32'h0b1, 32'h2d5};

    always #5 pclk = ~pclk;

    charge_port_mode_load_detect #(.TICK_CYCLES(TC)) i_dut (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_select_a(a),
        .mode_select_b(b), .mode_select_c(c), .limit_choice(ch),
        .above_lo_plus(above), .below_lo_minus(below), .below_wake(bwake),
        .at_wake_limit(atw), .bc12_primary(bc12), .hid_detected(hid),
        .phone_dcp_no_data(pdcp), .phone_sdp_connected(psdp),
        .load_present_n(lp_n), .port_discharge(dis), .port_power_on(pwr),
        .upper_limit_sel(up), .wake_limit_sel(wk), .data_lines_on(dat));

    sys_power_model i_sys (.pclk(pclk), .presetn(presetn), .req(req),
        .load_present_n(lp_n), .other_load_n(other_n), .mode_select_a(a),
        .mode_select_b(b), .mode_select_c(c), .limit_choice(ch));

    always @(posedge pclk) if (dis === 1'b1) seen <= 1'b1;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic cmp_data(input logic [31:0] got, exp, m);
        cmp_count++;
        if (((got ^ exp) & m) !== 32'h0) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got & m, exp & m);
        end
    endtask : cmp_data

    task automatic cmp_err(input logic got, exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t err got %h exp %h", $time, got, exp);
        end
    endtask : cmp_err

    // monitor: each completed read takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            cmp_data(prdata, nt.d, nt.m);
            cmp_err(pslverr, nt.e);
            if (paddr == `CPM_ADDR_STATUS)
                cmp_data({pwr, dat, wk, up, dis, lp_n}, {~nt.d[1], nt.d[4:0]},
                    {nt.m[1], nt.m[4:0]});
        end
    end

    task automatic apb(input logic [11:0] ad, input logic w,
        input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            fail_count++;
            stop_test();
        end
    endtask : apb

    task automatic rd(input logic [11:0] ad, input logic [31:0] d, m,
        input logic e);
        notes.push_back('{d, m, e});
        apb(ad, 1'b0, 32'h0);
    endtask : rd

    task automatic st(input logic [31:0] d, m);
        rd(`CPM_ADDR_STATUS, d, m, 1'b0);
    endtask : st

    task automatic ticks(input int n);
        repeat (n * TC) @(posedge pclk);
    endtask : ticks

    task automatic tend(input string s);
        repeat (4) @(posedge pclk);
        $display("test done: %s", s);
    endtask : tend

    initial begin
        $urandom(97282);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CPM_ADDR_CTRL, `CPM_CTRL_RESET, 32'hffff_ffff, 1'b0);
        rd(12'h008, 32'h0, 32'hffff_ffff, 1'b1);
        tend("registers");
        for (i = 0; i < 16; i++) begin
            req <= i[3:0];
            ticks(5);
            st(tab[i], (i < 2) ? 32'h3eb : 32'h3ff);
        end
        tend("mode table");
        g = 20 + $urandom % 150;
        above <= 1'b1;
        ticks(g);
        above <= 1'b0;
        ticks(1);
        above <= 1'b1;
        ticks(190);
        st(32'h1, 32'h1);
        ticks(20);
        st(32'h0, 32'h1);
        above <= 1'b0;
        below <= 1'b1;
        ticks(2990);
        st(32'h0, 32'h1);
        ticks(20);
        st(32'h1, 32'h1);
        below <= 1'b0;
        tend("budget timing");
        for (i = 0; i < 3; i++) begin
            req <= (i == 0) ? 4'h7 : ((i == 1) ? 4'h6 : 4'h2);
            ticks(5);
            above <= 1'b1;
            ticks(210);
            st({31'h0, i != 0}, 32'h1);
            above <= 1'b0;
        end
        tend("auto detection");
        req <= 4'h3;
        ticks(5);
        st(32'h0, 32'h9);
        bwake <= 1'b1;
        ticks(14990);
        st(32'h0, 32'h9);
        ticks(20);
        st(32'h409, 32'hc09);
        atw <= 1'b1;
        bwake <= 1'b0;
        ticks(3);
        st(32'h2, 32'h3);
        atw <= 1'b0;
        ticks(1985);
        st(32'h2, 32'h3);
        ticks(25);
        st(32'h4, 32'hf);
        tend("low drain");
        req <= 4'hf;
        ticks(5);
        seen <= 1'b0;
        other_n <= 1'b0;
        ticks(5);
        st(32'h0a0, 32'h0e4);
        other_n <= 1'b1;
        ticks(5);
        st(32'h0c4, 32'h0e4);
        cmp_data({31'h0, seen}, 32'h0, 32'h1);
        hid <= 1'b1;
        ticks(5);
        req <= 4'h7;
        ticks(5);
        st(32'h0c0, 32'h0e0);
        req <= 4'hf;
        hid <= 1'b0;
        tend("paired and hid");
        ticks(5);
        pdcp <= 1'b1;
        ticks(3);
        pdcp <= 1'b0;
        st(32'h1002, 32'h3012);
        ticks(490);
        st(32'h1002, 32'h3012);
        ticks(20);
        st(32'h2010, 32'h3016);
        seen <= 1'b0;
        psdp <= 1'b1;
        ticks(3);
        psdp <= 1'b0;
        st(32'h00d4, 32'h30f6);
        cmp_data({31'h0, seen}, 32'h0, 32'h1);
        apb(`CPM_ADDR_CTRL, 1'b1, 32'hffff_ff00);
        rd(`CPM_ADDR_CTRL, 32'h0, 32'hffff_ffff, 1'b0);
        pdcp <= 1'b1;
        ticks(5);
        pdcp <= 1'b0;
        st(32'h0, 32'h3002);
        apb(`CPM_ADDR_CTRL, 1'b1, 32'h1);
        tend("auto switch");
        bc12 <= 1'b1;
        ticks(5);
        st(32'h0, 32'h1);
        bc12 <= 1'b0;
        tend("primary detection");
        stop_test();
    end
endmodule : tb_top
